// [rtl/prm_params.svh]
`ifndef PRM_PARAMS_SVH
`define PRM_PARAMS_SVH

// register indices in the management register space
`define PRM_IDX_P1_TABLE   16'h1856
`define PRM_IDX_P2_TABLE   16'h1857
`define PRM_IDX_P0_DROPCNT 16'h1858

// identity table after reset: entry n holds n
`define PRM_TABLE_RESET    24'hFAC688
`define PRM_TABLE_WIDTH    24
`define PRM_ENTRY_WIDTH    3
`define PRM_CNT_RESET      32'h0000_0000
`define PRM_CNT_MAX        32'hFFFF_FFFF

`endif

// [rtl/prm_pkg.sv]
package prm_pkg;
  typedef logic [2:0]  prm_prio_t;
  typedef logic [23:0] prm_table_t;
  typedef logic [31:0] prm_word_t;
endpackage : prm_pkg

// [rtl/prm_lookup.sv]
`include "prm_params.svh"

// one remapping table lookup, registered
module prm_lookup (
  input  wire logic                clk_sys,     // core clock
  input  wire logic                rst,         // async reset, active high
  input  wire prm_pkg::prm_table_t table_val,   // current table contents
  input  wire logic                frame_valid, // received frame header valid
  input  wire prm_pkg::prm_prio_t  rx_prio,     // received vlan priority
  output logic                     regen_valid, // regenerated priority valid
  output prm_pkg::prm_prio_t       regen_prio   // regenerated priority
);

  function automatic prm_pkg::prm_prio_t prm_entry(input prm_pkg::prm_table_t t,
                                                   input prm_pkg::prm_prio_t p);
    prm_entry = t[{p, 1'b0} + {2'b00, p} +: `PRM_ENTRY_WIDTH];
  endfunction : prm_entry

  wire prm_pkg::prm_prio_t mapped = prm_entry(table_val, rx_prio);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      regen_valid <= 1'b0;
      regen_prio  <= 3'h0;
    end else begin
      regen_valid <= frame_valid;
      if (frame_valid) begin
        regen_prio <= mapped;
      end
    end
  end

  regen_follow_a: assert property (@(posedge clk_sys) disable iff (rst)
    frame_valid |=> regen_valid && regen_prio == $past(mapped))
    else $error("regenerated priority does not follow table");

endmodule : prm_lookup

// [rtl/prm_regs.sv]
`include "prm_params.svh"

module prm_regs (
  input  wire logic               clk_sys,        // core clock, 40 MHz
  input  wire logic               rst,            // async reset, active high
  input  wire logic [15:0]        reg_addr,       // register index
  input  wire logic               reg_wr,         // write strobe, one cycle
  input  wire logic               reg_rd,         // read strobe, one cycle
  input  wire prm_pkg::prm_word_t reg_wdata,      // write data
  output prm_pkg::prm_word_t      reg_rdata,      // read data, registered
  output logic                    reg_rvalid,     // read data valid pulse
  input  wire logic               p1_frame_valid, // port 1 frame header pulse
  input  wire prm_pkg::prm_prio_t p1_rx_prio,     // port 1 received priority
  input  wire logic               p2_frame_valid, // port 2 frame header pulse
  input  wire prm_pkg::prm_prio_t p2_rx_prio,     // port 2 received priority
  output logic                    p1_queue_valid, // port 1 queue select valid
  output prm_pkg::prm_prio_t      p1_queue_prio,  // port 1 priority for queue choice
  output logic                    p2_queue_valid, // port 2 queue select valid
  output prm_pkg::prm_prio_t      p2_queue_prio,  // port 2 priority for queue choice
  input  wire logic               p0_not_learned, // port 0 source address not learned
  input  wire logic               p0_overwrite    // port 0 address overwrote another
);

  prm_pkg::prm_table_t p1_table_reg;
  prm_pkg::prm_table_t p2_table_reg;
  prm_pkg::prm_word_t  p0_cnt_reg;
  prm_pkg::prm_word_t  p0_cnt_next;

  // entry n of a table sits at bits 3n+2:3n; the priority checks below read table entries through this
  function automatic prm_pkg::prm_prio_t prm_pick(input prm_pkg::prm_table_t t,
                                                  input prm_pkg::prm_prio_t  p);
    prm_pick = t[3 * p +: `PRM_ENTRY_WIDTH];
  endfunction : prm_pick

  wire logic sel_p1  = reg_addr == `PRM_IDX_P1_TABLE;
  wire logic sel_p2  = reg_addr == `PRM_IDX_P2_TABLE;
  wire logic sel_cnt = reg_addr == `PRM_IDX_P0_DROPCNT;
  wire logic cnt_clear = reg_rd && sel_cnt;
  // both learn events may coincide; they arrive as one count each
  wire logic [1:0] cnt_events = {1'b0, p0_not_learned} + {1'b0, p0_overwrite};
  wire logic [32:0] cnt_sum = {1'b0, p0_cnt_reg} + {31'h0, cnt_events};
  wire logic cnt_sat = cnt_sum[32];

  // a read clears the count it returned; events of that same cycle are kept
  assign p0_cnt_next = cnt_clear ? {30'h0, cnt_events} :
                       (cnt_sat ? `PRM_CNT_MAX : cnt_sum[31:0]);

  wire prm_pkg::prm_word_t rd_mux = sel_p1  ? {8'h00, p1_table_reg} :
                                    sel_p2  ? {8'h00, p2_table_reg} :
                                    sel_cnt ? p0_cnt_reg : 32'h0000_0000;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      p1_table_reg <= `PRM_TABLE_RESET;
      p2_table_reg <= `PRM_TABLE_RESET;
    end else if (reg_wr) begin
      if (sel_p1) p1_table_reg <= reg_wdata[23:0];
      if (sel_p2) p2_table_reg <= reg_wdata[23:0];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      p0_cnt_reg <= `PRM_CNT_RESET;
    end else begin
      p0_cnt_reg <= p0_cnt_next;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata  <= 32'h0000_0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) reg_rdata <= rd_mux;
    end
  end

  // queue choice sees only the regenerated priority
  prm_lookup u_p1_lookup (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .table_val   (p1_table_reg),
    .frame_valid (p1_frame_valid),
    .rx_prio     (p1_rx_prio),
    .regen_valid (p1_queue_valid),
    .regen_prio  (p1_queue_prio)
  );

  prm_lookup u_p2_lookup (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .table_val   (p2_table_reg),
    .frame_valid (p2_frame_valid),
    .rx_prio     (p2_rx_prio),
    .regen_valid (p2_queue_valid),
    .regen_prio  (p2_queue_prio)
  );

  p1_map_a: assert property (@(posedge clk_sys) disable iff (rst)
    p1_frame_valid |=> p1_queue_prio == $past(prm_pick(p1_table_reg, p1_rx_prio)))
    else $error("port 1 queue priority wrong");

  p2_map_a: assert property (@(posedge clk_sys) disable iff (rst)
    p2_frame_valid |=> p2_queue_prio == $past(prm_pick(p2_table_reg, p2_rx_prio)))
    else $error("port 2 queue priority wrong");

  cnt_saturate_a: assert property (@(posedge clk_sys) disable iff (rst)
    ($past(p0_cnt_reg) == `PRM_CNT_MAX && !$past(cnt_clear)) |-> p0_cnt_reg == `PRM_CNT_MAX)
    else $error("counter wrapped");

  cnt_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    cnt_clear |=> reg_rvalid && reg_rdata == $past(p0_cnt_reg) && p0_cnt_reg <= 32'h0000_0002)
    else $error("counter read did not return and clear");

  cnt_incr_a: assert property (@(posedge clk_sys) disable iff (rst)
    (p0_not_learned && !p0_overwrite && !cnt_clear && p0_cnt_reg != `PRM_CNT_MAX)
      |=> p0_cnt_reg == $past(p0_cnt_reg) + 32'h0000_0001)
    else $error("not learned event not counted");

  cnt_over_a: assert property (@(posedge clk_sys) disable iff (rst)
    (p0_overwrite && !p0_not_learned && !cnt_clear && p0_cnt_reg != `PRM_CNT_MAX)
      |=> p0_cnt_reg == $past(p0_cnt_reg) + 32'h0000_0001)
    else $error("overwrite event not counted");

  table_hi_a: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_rd && (sel_p1 || sel_p2)) |=> reg_rdata[31:24] == 8'h00)
    else $error("reserved table bits not zero");

  table_wr_a: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && sel_p1) |=> p1_table_reg == $past(reg_wdata[23:0]))
    else $error("port 1 table write lost");

  // tables and counter leave reset at their reset values; tables hold their contents unless written, and read back with a zero top byte
  reset_vals_a: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(rst) |-> p1_table_reg == `PRM_TABLE_RESET && p2_table_reg == `PRM_TABLE_RESET
                   && p0_cnt_reg == `PRM_CNT_RESET)
    else $error("register contents wrong after reset");

  p2_table_wr_a: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && sel_p2) |=> p2_table_reg == $past(reg_wdata[23:0]))
    else $error("port 2 table write lost");

  p1_table_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
    !(reg_wr && sel_p1) |=> $stable(p1_table_reg))
    else $error("port 1 table changed without a write");

  p2_table_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
    !(reg_wr && sel_p2) |=> $stable(p2_table_reg))
    else $error("port 2 table changed without a write");

  p1_table_rd_a: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_rd && sel_p1) |=> reg_rdata == {8'h00, $past(p1_table_reg)})
    else $error("port 1 table read wrong");

  p2_table_rd_a: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_rd && sel_p2) |=> reg_rdata == {8'h00, $past(p2_table_reg)})
    else $error("port 2 table read wrong");

  // lookup: one result per frame, and the priority stands until the next frame
  p1_valid_a: assert property (@(posedge clk_sys) disable iff (rst)
    p1_queue_valid == $past(p1_frame_valid))
    else $error("port 1 queue valid not one cycle after frame");

  p2_valid_a: assert property (@(posedge clk_sys) disable iff (rst)
    p2_queue_valid == $past(p2_frame_valid))
    else $error("port 2 queue valid not one cycle after frame");

  p1_prio_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    !p1_frame_valid |=> $stable(p1_queue_prio))
    else $error("port 1 queue priority changed without a frame");

  p2_prio_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    !p2_frame_valid |=> $stable(p2_queue_prio))
    else $error("port 2 queue priority changed without a frame");

  // counter: reaching all ones takes 2^32 - 1 events, far beyond any run, so cnt_saturate_a
  // only bites in formal runs; cnt_mono_a catches a wrap on any value instead
  cnt_both_a: assert property (@(posedge clk_sys) disable iff (rst)
    (p0_not_learned && p0_overwrite && !cnt_clear && p0_cnt_reg < `PRM_CNT_MAX - 32'h0000_0001)
      |=> p0_cnt_reg == $past(p0_cnt_reg) + 32'h0000_0002)
    else $error("coinciding learn events not counted twice");

  cnt_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!p0_not_learned && !p0_overwrite && !cnt_clear)
      |=> $stable(p0_cnt_reg))
    else $error("counter changed without an event");

  cnt_wr_ignore_a: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && sel_cnt && !p0_not_learned && !p0_overwrite && !cnt_clear)
      |=> $stable(p0_cnt_reg))
    else $error("counter changed by a write");

  cnt_mono_a: assert property (@(posedge clk_sys) disable iff (rst)
    !cnt_clear |=> p0_cnt_reg >= $past(p0_cnt_reg))
    else $error("counter went down without a read");

  clear_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
    cnt_clear |=> p0_cnt_reg == $past({31'h0, p0_not_learned}) + $past({31'h0, p0_overwrite}))
    else $error("events during clearing read lost");

  rd_valid_a: assert property (@(posedge clk_sys) disable iff (rst)
    reg_rvalid == $past(reg_rd))
    else $error("read valid not one cycle after read");

  rdata_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

endmodule : prm_regs

// [dv/tb.sv]
`include "prm_params.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk_sys = 1'b0;
  logic               rst = 1'b1;
  logic [15:0]        reg_addr = 16'h0000;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  prm_pkg::prm_word_t reg_wdata = 32'h0000_0000;
  prm_pkg::prm_word_t reg_rdata;
  logic               reg_rvalid;
  logic               p1_frame_valid = 1'b0;
  logic               p2_frame_valid = 1'b0;
  prm_pkg::prm_prio_t p1_rx_prio = 3'h0;
  prm_pkg::prm_prio_t p2_rx_prio = 3'h0;
  logic               p1_queue_valid;
  logic               p2_queue_valid;
  prm_pkg::prm_prio_t p1_queue_prio;
  prm_pkg::prm_prio_t p2_queue_prio;
  logic               p0_not_learned = 1'b0;
  logic               p0_overwrite = 1'b0;
  int                 err_total = 0;
  int                 check_count = 0;
  int                 cyc = 0;
  integer             seed = 32'h892B;
  prm_pkg::prm_word_t q_reg[$];
  prm_pkg::prm_word_t q_p1[$];
  prm_pkg::prm_word_t q_p2[$];
  prm_pkg::prm_table_t t1 = `PRM_TABLE_RESET;
  prm_pkg::prm_table_t t2 = `PRM_TABLE_RESET;
  prm_pkg::prm_word_t w;
  prm_pkg::prm_word_t cnt = 32'h0000_0000;

  prm_regs dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .p1_frame_valid(p1_frame_valid),
    .p1_rx_prio(p1_rx_prio), .p2_frame_valid(p2_frame_valid), .p2_rx_prio(p2_rx_prio),
    .p1_queue_valid(p1_queue_valid), .p1_queue_prio(p1_queue_prio), .p2_queue_valid(p2_queue_valid),
    .p2_queue_prio(p2_queue_prio), .p0_not_learned(p0_not_learned), .p0_overwrite(p0_overwrite));

  always #12.5 clk_sys = ~clk_sys;

  task automatic chk(input prm_pkg::prm_word_t seen, input prm_pkg::prm_word_t exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic stop_test();
    if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  task automatic wr(input logic [15:0] a, input prm_pkg::prm_word_t d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input prm_pkg::prm_word_t exp);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    q_reg.push_back(exp);
    @(negedge clk_sys);
    reg_rd = 1'b0;
  endtask : rd

  // both ports in the same cycle, so a shared table would show up as a mismatch
  task automatic fr(input prm_pkg::prm_prio_t a, input prm_pkg::prm_prio_t b);
    @(negedge clk_sys);
    p1_frame_valid = 1'b1;
    p1_rx_prio = a;
    q_p1.push_back({29'h0, t1[3*a +: 3]});
    p2_frame_valid = 1'b1;
    p2_rx_prio = b;
    q_p2.push_back({29'h0, t2[3*b +: 3]});
    @(negedge clk_sys);
    p1_frame_valid = 1'b0;
    p2_frame_valid = 1'b0;
  endtask : fr

  // an empty queue yields unknowns, so unexpected results count as mismatches
  always @(negedge clk_sys) begin
    if (reg_rvalid === 1'b1) chk(reg_rdata, q_reg.size() ? q_reg.pop_front() : 'X);
    if (p1_queue_valid === 1'b1) chk({29'h0, p1_queue_prio}, q_p1.size() ? q_p1.pop_front() : 'X);
    if (p2_queue_valid === 1'b1) chk({29'h0, p2_queue_prio}, q_p2.size() ? q_p2.pop_front() : 'X);
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      stop_test();
    end
  end

  initial begin
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    rd(`PRM_IDX_P1_TABLE, {8'h00, `PRM_TABLE_RESET});
    rd(`PRM_IDX_P2_TABLE, {8'h00, `PRM_TABLE_RESET});
    rd(`PRM_IDX_P0_DROPCNT, `PRM_CNT_RESET);
    rd(16'h1855, 32'h0000_0000);
    for (int i = 0; i < 8; i++) fr(3'(i), 3'(7 - i));
    w = $random(seed);
    wr(`PRM_IDX_P1_TABLE, w);
    t1 = w[23:0];
    w = $random(seed);
    wr(`PRM_IDX_P2_TABLE, w);
    t2 = w[23:0];
    wr(`PRM_IDX_P0_DROPCNT, 32'hFFFF_FFFF);
    rd(`PRM_IDX_P1_TABLE, {8'h00, t1});
    rd(`PRM_IDX_P2_TABLE, {8'h00, t2});
    for (int i = 0; i < 8; i++) fr(3'(i), 3'(i));
    for (int i = 0; i < 20; i++) fr(3'($random(seed)), 3'($random(seed)));
    for (int i = 0; i < 40; i++) begin
      @(negedge clk_sys);
      p0_not_learned = 1'($random(seed));
      p0_overwrite = 1'($random(seed));
      cnt = cnt + p0_not_learned + p0_overwrite;
    end
    @(negedge clk_sys);
    p0_not_learned = 1'b1;
    p0_overwrite = 1'b1;
    cnt = cnt + 32'h0000_0002;
    // both events stand through the clearing read, so they must survive into the cleared count
    rd(`PRM_IDX_P0_DROPCNT, cnt);
    p0_not_learned = 1'b0;
    p0_overwrite = 1'b0;
    rd(`PRM_IDX_P0_DROPCNT, 32'h0000_0002);
    rd(`PRM_IDX_P0_DROPCNT, 32'h0000_0000);
    repeat (3) @(negedge clk_sys);
    if (q_reg.size() + q_p1.size() + q_p2.size() != 0) err_total++;
    stop_test();
  end
endmodule : tb
